// [hw/lut_ram_device.sv]
// Purpose: logic cell configured as dual-port ram, or legacy level-sensitive ram
// Assumes: driving logic keeps its own timing duties in level-sensitive mode
// Notes: port outputs are combinational, reads do not wait for a clock edge
`timescale 1ns/100ps
`default_nettype none
module lut_ram_device
  import lut_ram_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // ram pins
  lut_ram_if.device ram,
  // status
  output logic level_fault
);
  dev_state_t st_r;
  dev_state_t st_nxt;
  logic half_we;
  logic half_wdata;
  logic glitch;
  logic [ADDR_W-1:0] raddr [NUM_HALVES];
  logic rdata [NUM_HALVES];

  assign raddr[0] = ram.shared_addr;
  assign raddr[1] = ram.second_read_address;

  always_comb
  begin
    st_nxt = st_r;
    glitch = 1'b0;
    if (ram.single_port_level)
    begin
      // latch-like: every cycle with enable high writes, inverting the data if the address moved while enable stayed high
      glitch = ram.wr_en && st_r.prev_we && (ram.shared_addr != st_r.prev_addr);
      half_we = ram.wr_en;
      half_wdata = glitch ? ~ram.wr_data : ram.wr_data;
    end
    else
    begin
      half_we = ram.wr_en && ram.wclk_en;
      half_wdata = ram.wr_data;
    end
    st_nxt.prev_addr = ram.shared_addr;
    st_nxt.prev_we = ram.wr_en && ram.single_port_level;
    if (glitch)
    begin
      st_nxt.fault = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '{prev_addr: ADDR_RESET, prev_we: 1'b0, fault: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // both halves share write address and data, so contents stay identical
  for (genvar g = 0; g < NUM_HALVES; g++)
  begin : g_half
    lut_ram_half u_half (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .we(half_we),
      .waddr(ram.shared_addr),
      .wdata(half_wdata),
      .raddr(raddr[g]),
      .rdata(rdata[g])
    );
  end

  // in level mode the open latch passes the incoming data straight through
  always_comb
  begin
    if (ram.single_port_level && ram.wr_en)
    begin
      ram.first_port_out = half_wdata;
      ram.second_port_out = (ram.second_read_address == ram.shared_addr) ? half_wdata : rdata[1];
    end
    else
    begin
      ram.first_port_out = rdata[0];
      ram.second_port_out = rdata[1];
    end
  end

  assign level_fault = st_r.fault;
endmodule
`default_nettype wire

// [hw/lut_ram_half.sv]
// Purpose: one 16x1 lookup half with one write port and an asynchronous read
// Assumes: write strobe is a same-clock level
// Notes: read path is purely combinational
`timescale 1ns/100ps
`default_nettype none
module lut_ram_half
  import lut_ram_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // write port
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic wdata,
  // read port
  input wire logic [ADDR_W-1:0] raddr,
  output logic rdata
);
  half_state_t st_r;
  half_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (we)
    begin
      st_nxt.bits[waddr] = wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '{bits: MEM_RESET};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.bits[raddr];
endmodule
`default_nettype wire

// [hw/lut_ram_if.sv]
// Purpose: pins between the lookup ram cell and the fabric logic that drives it
// Assumes: all signals on sys_clk
// Notes: write clock edge is carried as the one-cycle enable wclk_en
`timescale 1ns/100ps
`default_nettype none
interface lut_ram_if;
  import lut_ram_pkg::*;
  logic [ADDR_W-1:0] shared_addr;
  logic [ADDR_W-1:0] second_read_address;
  logic wr_data;
  logic wr_en;
  logic wclk_en;
  logic single_port_level;
  logic first_port_out;
  logic second_port_out;

  modport device (
    input shared_addr, second_read_address, wr_data, wr_en, wclk_en, single_port_level,
    output first_port_out, second_port_out
  );
  modport user (
    output shared_addr, second_read_address, wr_data, wr_en, wclk_en, single_port_level,
    input first_port_out, second_port_out
  );
endinterface
`default_nettype wire

// [hw/lut_ram_pkg.sv]
// Purpose: shared constants and types for the dual-port lookup ram and its user
// Assumes: one system clock at 20 MHz
// Notes: storage is cleared by reset so that simulation starts from known contents
package lut_ram_pkg;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam int NUM_HALVES = 2;
  localparam logic [DEPTH-1:0] MEM_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 4'h0;
  localparam int CLK_HZ = 20000000;
  localparam int STALL_LIMIT_MS = 1;
  localparam int STALL_LIMIT_CYCLES = (CLK_HZ / 1000) * STALL_LIMIT_MS;
  localparam int WCLK_DIV_DEFAULT = 4;
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;

  typedef struct packed {
    logic [DEPTH-1:0] bits;
  } half_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] prev_addr;
    logic prev_we;
    logic fault;
  } dev_state_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_EDGE_WAIT = 6'h02,
    ST_LVL_SETUP = 6'h04,
    ST_LVL_PULSE = 6'h08,
    ST_LVL_HOLD = 6'h10,
    ST_READ = 6'h20
  } user_state_t;

  typedef struct packed {
    user_state_t state;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] rd_addr;
    logic data;
    logic we;
    logic level;
    logic [DIV_W-1:0] div;
    logic wclk_en;
    logic rd1;
    logic rd2;
    logic done;
  } user_reg_t;
endpackage

// [hw/lut_ram_user.sv]
// Purpose: fabric logic that drives the lookup ram cell from simple commands
// Assumes: one command at a time, taken when cmd_ready is high
// Notes: write clock is a free-running divider enable, never stalled
`timescale 1ns/100ps
`default_nettype none
module lut_ram_user
  import lut_ram_pkg::*;
#(
  parameter int WCLK_DIV = WCLK_DIV_DEFAULT,
  parameter int STALL_CYCLES = STALL_LIMIT_CYCLES
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // ram pins
  lut_ram_if.user ram,
  // command
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_level,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [ADDR_W-1:0] cmd_rd_addr,
  input wire logic cmd_data,
  output logic cmd_ready,
  // result
  output logic rsp_valid,
  output logic rsp_first,
  output logic rsp_second
);
  localparam int DIV_USED = (WCLK_DIV < STALL_CYCLES) ? WCLK_DIV : STALL_CYCLES - 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_USED - 1);

  user_reg_t r_r;
  user_reg_t r_nxt;

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    // write clock period bounded to at most STALL_CYCLES - 1 cycles, below the stall limit
    if (r_r.div >= DIV_LAST)
    begin
      r_nxt.div = DIV_RESET;
      r_nxt.wclk_en = 1'b1;
    end
    else
    begin
      r_nxt.div = r_r.div + 16'h0001;
      r_nxt.wclk_en = 1'b0;
    end
    case (r_r.state)
      ST_IDLE:
      begin
        if (cmd_valid)
        begin
          r_nxt.addr = cmd_addr;
          r_nxt.rd_addr = cmd_rd_addr;
          r_nxt.data = cmd_data;
          r_nxt.level = cmd_level;
          if (!cmd_write)
          begin
            r_nxt.state = ST_READ;
          end
          else if (cmd_level)
          begin
            r_nxt.state = ST_LVL_SETUP;
          end
          else
          begin
            r_nxt.we = 1'b1;
            r_nxt.state = ST_EDGE_WAIT;
          end
        end
      end
      ST_EDGE_WAIT:
      begin
        // the device writes on the edge that ends a cycle with wclk_en high
        if (r_r.wclk_en)
        begin
          r_nxt.we = 1'b0;
          r_nxt.rd1 = ram.first_port_out;
          r_nxt.rd2 = ram.second_port_out;
          r_nxt.done = 1'b1;
          r_nxt.state = ST_IDLE;
        end
      end
      ST_LVL_SETUP:
      begin
        r_nxt.we = 1'b1;
        r_nxt.state = ST_LVL_PULSE;
      end
      ST_LVL_PULSE:
      begin
        r_nxt.we = 1'b0;
        r_nxt.state = ST_LVL_HOLD;
      end
      ST_LVL_HOLD:
      begin
        // address and data held one cycle past the enable falling edge
        r_nxt.rd1 = ram.first_port_out;
        r_nxt.rd2 = ram.second_port_out;
        r_nxt.done = 1'b1;
        r_nxt.state = ST_IDLE;
      end
      ST_READ:
      begin
        r_nxt.rd1 = ram.first_port_out;
        r_nxt.rd2 = ram.second_port_out;
        r_nxt.done = 1'b1;
        r_nxt.state = ST_IDLE;
      end
      default:
      begin
        r_nxt.we = 1'b0;
        r_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_r <= '{state: ST_IDLE, addr: ADDR_RESET, rd_addr: ADDR_RESET, data: 1'b0, we: 1'b0,
               level: 1'b0, div: DIV_RESET, wclk_en: 1'b0, rd1: 1'b0, rd2: 1'b0, done: 1'b0};
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign ram.shared_addr = r_r.addr;
  assign ram.second_read_address = r_r.rd_addr;
  assign ram.wr_data = r_r.data;
  assign ram.wr_en = r_r.we;
  assign ram.wclk_en = r_r.wclk_en;
  assign ram.single_port_level = r_r.level;
  assign cmd_ready = (r_r.state == ST_IDLE);
  assign rsp_valid = r_r.done;
  assign rsp_first = r_r.rd1;
  assign rsp_second = r_r.rd2;
endmodule
`default_nettype wire

// [tb/dual_port_lut_ram_tb.sv]
// Purpose: self-checking bench for the lookup ram and its user logic
// Assumes: commands issued only while the user logic is idle
// Notes: stall limit shortened to keep the run short
`timescale 1ns/100ps
`default_nettype none
module dual_port_lut_ram_tb
  import lut_ram_pkg::*;
;
  logic sys_clk, resetn, cmd_valid, cmd_write, cmd_level, cmd_data;
  logic cmd_ready, rsp_valid, rsp_first, rsp_second, level_fault;
  logic [ADDR_W-1:0] cmd_addr, cmd_rd_addr;
  logic [DEPTH-1:0] mem;
  int mismatches, checks_done, cycles;
  localparam logic [DEPTH-1:0] SWEEP_PAT = 16'ha5c3;

  lut_ram_if ram();
  lut_ram_device u_lut_ram_device(.sys_clk(sys_clk), .resetn(resetn), .ram(ram.device),
    .level_fault(level_fault));
  lut_ram_user #(.WCLK_DIV(4), .STALL_CYCLES(16)) u_lut_ram_user(.sys_clk(sys_clk),
    .resetn(resetn), .ram(ram.user), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_level(cmd_level), .cmd_addr(cmd_addr), .cmd_rd_addr(cmd_rd_addr),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_first(rsp_first), .rsp_second(rsp_second));
  lut_ram_assertions u_lut_ram_assertions(.sys_clk(sys_clk), .resetn(resetn),
    .shared_addr(ram.shared_addr), .second_read_address(ram.second_read_address),
    .wr_data(ram.wr_data), .wr_en(ram.wr_en), .wclk_en(ram.wclk_en),
    .single_port_level(ram.single_port_level), .first_port_out(ram.first_port_out),
    .second_port_out(ram.second_port_out));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task complete_run;
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  task automatic check(input string name, input logic exp, input logic seen);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic cmd(input logic w, input logic l, input logic [3:0] a, input logic [3:0] r,
    input logic d);
    @(negedge sys_clk);
    {cmd_valid, cmd_write, cmd_level, cmd_addr, cmd_rd_addr, cmd_data} = {1'b1, w, l, a, r, d};
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    for (int k = 0; k < 12 && rsp_valid !== 1'b1; k++) @(negedge sys_clk);
    check("rsp_valid", 1'b1, rsp_valid);
  endtask

  task automatic rd(input logic [3:0] a, input logic [3:0] r);
    cmd(1'b0, 1'b0, a, r, 1'b0);
    check("rsp_first", mem[a], rsp_first);
    check("rsp_second", mem[r], rsp_second);
    check("first_pin", mem[ram.shared_addr], ram.first_port_out);
    check("second_pin", mem[ram.second_read_address], ram.second_port_out);
  endtask

  task automatic wr(input logic [3:0] a, input logic [3:0] r, input logic d, input logic l);
    cmd(1'b1, l, a, r, d);
    check("wr_first", l ? d : mem[a], rsp_first);
    check("wr_second", (l && r == a) ? d : mem[r], rsp_second);
    mem[a] = d;
  endtask

  task t_edge;
    wr(4'h3, 4'h5, 1'b1, 1'b0);
    wr(4'h5, 4'h3, 1'b1, 1'b0);
    rd(4'h3, 4'h5);
  endtask

  task t_same;
    rd(4'h5, 4'h5);
    wr(4'h5, 4'h5, 1'b0, 1'b0);
    rd(4'h5, 4'h5);
  endtask

  task t_level;
    wr(4'ha, 4'h3, 1'b1, 1'b1);
    rd(4'ha, 4'ha);
    wr(4'ha, 4'h3, 1'b0, 1'b1);
    rd(4'ha, 4'h3);
    check("level_fault", 1'b0, level_fault);
  endtask

  task t_sweep;
    for (int i = 0; i < DEPTH; i++) wr(i[3:0], ~i[3:0], SWEEP_PAT[i], 1'b0);
    for (int i = 0; i < DEPTH; i++) rd(i[3:0], ~i[3:0]);
  endtask

  task t_reset;
    @(negedge sys_clk);
    resetn = 1'b0;
    @(negedge sys_clk);
    check("reset_first", 1'b0, ram.first_port_out);
    check("reset_second", 1'b0, ram.second_port_out);
    resetn = 1'b1;
    mem = MEM_RESET;
    rd(4'h0, 4'h3);
  endtask

  initial
  begin
    {resetn, cmd_valid, cmd_write, cmd_level, cmd_data} = '0;
    {cmd_addr, cmd_rd_addr} = '0;
    {mismatches, checks_done, cycles} = '0;
    mem = MEM_RESET;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    t_edge();
    t_same();
    t_level();
    t_sweep();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire

// [tb/lut_ram_assertions.sv]
// Purpose: pin-level checks on the lookup ram cell
// Assumes: one clock domain, reset active low
// Notes: watches what the device drives on its two read ports
`timescale 1ns/100ps
`default_nettype none
module lut_ram_assertions
  import lut_ram_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // ram pins
  input wire logic [ADDR_W-1:0] shared_addr,
  input wire logic [ADDR_W-1:0] second_read_address,
  input wire logic wr_data,
  input wire logic wr_en,
  input wire logic wclk_en,
  input wire logic single_port_level,
  input wire logic first_port_out,
  input wire logic second_port_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  wire logic edge_wr = !single_port_level && wr_en && wclk_en;
  wire logic lvl_wr = single_port_level && wr_en;

  property p_edge_first;
    edge_wr ##1 ($stable(shared_addr) && !wr_en) |-> first_port_out == $past(wr_data);
  endproperty
  a_edge_first: assert property (p_edge_first) else $error("first port missed write");
  property p_edge_second;
    edge_wr ##1 (second_read_address == $past(shared_addr) && !wr_en)
      |-> second_port_out == $past(wr_data);
  endproperty
  a_edge_second: assert property (p_edge_second) else $error("second half missed write");
  property p_no_write;
    (!single_port_level && !wclk_en) ##1 ((!wr_en || !single_port_level) && $stable(shared_addr))
      |-> $stable(first_port_out);
  endproperty
  a_no_write: assert property (p_no_write) else $error("write without clock edge");
  property p_same_addr;
    (!wr_en && shared_addr == second_read_address) |-> first_port_out == second_port_out;
  endproperty
  a_same_addr: assert property (p_same_addr) else $error("halves disagree");
  property p_transparent;
    (lvl_wr && $stable(shared_addr)) |-> first_port_out == wr_data;
  endproperty
  a_transparent: assert property (p_transparent) else $error("level write not shown");
  property p_level_keep;
    lvl_wr ##1 (!wr_en && $stable(shared_addr)) |-> first_port_out == $past(wr_data);
  endproperty
  a_level_keep: assert property (p_level_keep) else $error("level write lost");
  property p_hold_second;
    (!wr_en && !$past(wr_en) && $stable(second_read_address)) |-> $stable(second_port_out);
  endproperty
  a_hold_second: assert property (p_hold_second) else $error("second port moved");
  property p_indep;
    (edge_wr && shared_addr != second_read_address)
      ##1 ($stable(second_read_address) && !wr_en) |-> $stable(second_port_out);
  endproperty
  a_indep: assert property (p_indep) else $error("write disturbed other read");
  property p_lvl_settle;
    (single_port_level && (wr_en || $past(wr_en))) |-> $stable(shared_addr);
  endproperty
  a_lvl_settle: assert property (p_lvl_settle) else $error("address moved around enable");
  property p_lvl_data;
    (single_port_level && $fell(wr_en)) |-> $stable(wr_data) ##1 $stable(wr_data);
  endproperty
  a_lvl_data: assert property (p_lvl_data) else $error("data moved around enable fall");
  c_edge: cover property (edge_wr);
  c_level: cover property (lvl_wr);
  c_same: cover property (!wr_en && shared_addr == second_read_address);
endmodule
`default_nettype wire
